// File: hw/gpipc_pkg.sv
// Package for the GPIO pin interrupt and pad configuration block.
// Assumes a 32-bit register port with word offsets and 14 pins.
package gpipc_pkg;
  localparam int NPIN = 14;
  localparam int AW = 8;
  localparam logic [AW-1:0] OFF_MODE = 8'h28;
  localparam logic [AW-1:0] OFF_POL = 8'h2c;
  localparam logic [AW-1:0] OFF_EN = 8'h34;
  localparam logic [AW-1:0] OFF_FL = 8'h40;
  localparam logic [AW-1:0] OFF_CLR = 8'h48;
  localparam logic [AW-1:0] OFF_WAKE = 8'h4c;
  localparam logic [AW-1:0] OFF_DUAL = 8'h5c;
  localparam logic [AW-1:0] OFF_PULL = 8'h60;
  localparam logic [AW-1:0] OFF_AF0 = 8'h00;
  localparam logic [AW-1:0] OFF_AF1 = 8'h68;
  localparam logic [AW-1:0] OFF_HYS = 8'ha8;
  localparam logic [AW-1:0] OFF_SR = 8'hac;
  localparam logic [AW-1:0] OFF_DS0 = 8'hb0;
  localparam logic [AW-1:0] OFF_DS1 = 8'hb4;
  localparam logic [AW-1:0] OFF_PSEL = 8'hb8;
  localparam logic [NPIN-1:0] RST_ZERO = 14'h0000;
  // Pins that can carry the two-wire serial function: 9:8 and 3:2.
  localparam logic [NPIN-1:0] SERIAL_PINS = 14'h030c;
  localparam logic [NPIN-1:0] GENERAL_PINS = 14'h3cf3;
  localparam logic [1:0] AF_PLAIN_IO = 2'h0;
endpackage

// File: hw/gpipc_top.sv
// Per-pin interrupt detection and pad configuration for a 14-pin port.
// Assumes synchronous pad inputs and a single-cycle register port master.
// How it works
// [R1] Level mode: polarity picks active input level.
// [R2] Edge mode: polarity picks falling or rising.
// [R3] Polarity matters only with interrupt enabled.
// [R4] One interrupt enable bit per pin.
// [R5] Disabling interrupt keeps pending flag set.
// [R6] Flag register reads pending pins, resets zero.
// [R7] Writing one to clear register clears flag.
// [R8] Wakeup enable gates pin as wakeup source.
// [R9] Dual edge catches both edges in edge mode.
// [R10] General pins: pull enable turns on resistor.
// [R11] Serial pins: pull-down only, ignored if pull-up.
// [R12] Two select bits choose I/O or function.
// [R13] Hysteresis bit selects Schmitt input stage.
// [R14] General pins: slew bit one means slow.
// [R15] Serial pins have no slew control.
// [R16] General pins: two bits pick drive mode.
// [R17] Serial pins: first drive bit only.
// [R18] Software keeps reserved upper bits unchanged.
// [R19] Mode bit: zero level, one edge.
// [R20] Clearing a flag re-arms edge detection.
// [R21] Interrupts only in plain I/O, enabled.
// [R22] Request output while any enabled flag pends.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module gpipc_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [gpipc_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [gpipc_pkg::NPIN-1:0] pin_in,
  output logic irq_out,
  output logic [gpipc_pkg::NPIN-1:0] wakeup_req,
  output logic [gpipc_pkg::NPIN-1:0] pad_pull_up_en,
  output logic [gpipc_pkg::NPIN-1:0] pad_pull_down_en,
  output logic [gpipc_pkg::NPIN-1:0] pad_schmitt_en,
  output logic [gpipc_pkg::NPIN-1:0] pad_slow_slew,
  output logic [gpipc_pkg::NPIN-1:0] pad_drive_lo,
  output logic [gpipc_pkg::NPIN-1:0] pad_drive_hi,
  output logic [2*gpipc_pkg::NPIN-1:0] pad_func_sel
);
  import gpipc_pkg::*;

  logic [NPIN-1:0] trig_kind_r, pol_r, en_r, flag_r, wake_r, dual_r, pull_r;
  logic [NPIN-1:0] af0_r, af1_r, hys_r, sr_r, ds0_r, ds1_r, psel_r;
  logic [NPIN-1:0] pin_prev_r, hit, clr_w;
  logic [31:0] rdata_nxt;

  // Register writes; reserved bits are not stored, software keeps them. [R18]
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      trig_kind_r <= RST_ZERO;
      pol_r <= RST_ZERO;
      en_r <= RST_ZERO;
      wake_r <= RST_ZERO;
      dual_r <= RST_ZERO;
      pull_r <= RST_ZERO;
      af0_r <= RST_ZERO;
      af1_r <= RST_ZERO;
      hys_r <= RST_ZERO;
      sr_r <= RST_ZERO;
      ds0_r <= RST_ZERO;
      ds1_r <= RST_ZERO;
      psel_r <= RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        OFF_MODE: trig_kind_r <= reg_wdata[NPIN-1:0];
        OFF_POL: pol_r <= reg_wdata[NPIN-1:0];
        OFF_EN: en_r <= reg_wdata[NPIN-1:0]; // [R4]
        OFF_WAKE: wake_r <= reg_wdata[NPIN-1:0];
        OFF_DUAL: dual_r <= reg_wdata[NPIN-1:0];
        OFF_PULL: pull_r <= reg_wdata[NPIN-1:0];
        OFF_AF0: af0_r <= reg_wdata[NPIN-1:0];
        OFF_AF1: af1_r <= reg_wdata[NPIN-1:0];
        OFF_HYS: hys_r <= reg_wdata[NPIN-1:0];
        OFF_SR: sr_r <= reg_wdata[NPIN-1:0] & GENERAL_PINS; // [R15]
        OFF_DS0: ds0_r <= reg_wdata[NPIN-1:0];
        OFF_DS1: ds1_r <= reg_wdata[NPIN-1:0] & GENERAL_PINS; // [R17]
        OFF_PSEL: psel_r <= reg_wdata[NPIN-1:0];
        default: ;
      endcase
    end
  end

  // Previous pin level, the reference for edge detection.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_prev_r <= RST_ZERO;
    end else begin
      pin_prev_r <= pin_in;
    end
  end

  assign clr_w = (reg_wr && reg_addr == OFF_CLR) ? reg_wdata[NPIN-1:0] : RST_ZERO; // [R7]

  // Per-pin trigger decode. Polarity only reaches the flag through the enable.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      logic rise, fall, lvl, edg;
      assign rise = pin_in[g] & ~pin_prev_r[g];
      assign fall = ~pin_in[g] & pin_prev_r[g];
      assign lvl = pol_r[g] ? pin_in[g] : ~pin_in[g]; // [R1]
      assign edg = dual_r[g] ? (rise | fall) : (pol_r[g] ? rise : fall); // [R2] [R9]
      assign hit[g] = en_r[g] && ({af1_r[g], af0_r[g]} == AF_PLAIN_IO) // [R3] [R21]
                      && (trig_kind_r[g] ? edg : lvl); // [R19]
      assign pad_func_sel[2*g+1:2*g] = {af1_r[g], af0_r[g]}; // [R12]
    end
  endgenerate

  // Sticky flags: a new hit beats a clear in the same cycle, and the enable
  // never clears a flag. An edge after a clear sets it again. [R5] [R20]
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flag_r <= RST_ZERO; // [R6]
    end else begin
      flag_r <= (flag_r & ~clr_w) | hit; // [R7]
    end
  end

  assign irq_out = |(flag_r & en_r); // [R22]
  // Wakeup is asked only by pins with wakeup enabled and a pending edge event.
  assign wakeup_req = flag_r & wake_r & trig_kind_r; // [R8]

  // Pad controls. Serial pins only pull down, and not at all if pull-up is selected.
  assign pad_pull_up_en = pull_r & psel_r & GENERAL_PINS; // [R10]
  assign pad_pull_down_en = pull_r & ~psel_r; // [R11]
  assign pad_schmitt_en = hys_r; // [R13]
  assign pad_slow_slew = sr_r & GENERAL_PINS; // [R14]
  assign pad_drive_lo = ds0_r; // [R16]
  assign pad_drive_hi = ds1_r & GENERAL_PINS; // [R17]

  // Read mux; the clear register and unmapped offsets read as zero.
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (reg_addr)
      OFF_MODE: rdata_nxt[NPIN-1:0] = trig_kind_r;
      OFF_POL: rdata_nxt[NPIN-1:0] = pol_r;
      OFF_EN: rdata_nxt[NPIN-1:0] = en_r;
      OFF_FL: rdata_nxt[NPIN-1:0] = flag_r; // [R6]
      OFF_WAKE: rdata_nxt[NPIN-1:0] = wake_r;
      OFF_DUAL: rdata_nxt[NPIN-1:0] = dual_r;
      OFF_PULL: rdata_nxt[NPIN-1:0] = pull_r;
      OFF_AF0: rdata_nxt[NPIN-1:0] = af0_r;
      OFF_AF1: rdata_nxt[NPIN-1:0] = af1_r;
      OFF_HYS: rdata_nxt[NPIN-1:0] = hys_r;
      OFF_SR: rdata_nxt[NPIN-1:0] = sr_r;
      OFF_DS0: rdata_nxt[NPIN-1:0] = ds0_r;
      OFF_DS1: rdata_nxt[NPIN-1:0] = ds1_r;
      OFF_PSEL: rdata_nxt[NPIN-1:0] = psel_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 32'h00000000;
    end
  end

  // Checks kept beside the logic. Pin checks watch one to four pins rather than all, since
  // the generate loop builds the same hardware for every pin; spreading the
  // checks over different pins still catches a slip in one loop index.

  // Pin p is in plain I/O mode with its interrupt enabled.
  sequence s_armed(int p);
    en_r[p] && af0_r[p] == 1'b0 && af1_r[p] == 1'b0;
  endsequence

  // Pin p watches one edge only.
  sequence s_single_edge(int p);
    trig_kind_r[p] && !dual_r[p];
  endsequence

  // Pin p watches both edges.
  sequence s_both_edges(int p);
    trig_kind_r[p] && dual_r[p];
  endsequence

  // Pin p watches the input level.
  sequence s_level(int p);
    !trig_kind_r[p];
  endsequence

  // A rising edge with rising polarity sets the flag.
  rise_sets_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
    s_armed(0) ##0 s_single_edge(0) ##0 (pol_r[0] && pin_in[0] && !pin_prev_r[0])
    |=> flag_r[0]) else $error("rising edge did not set flag");

  // A falling edge with falling polarity sets the flag.
  fall_sets_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
    s_armed(5) ##0 s_single_edge(5) ##0 (!pol_r[5] && !pin_in[5] && pin_prev_r[5])
    |=> flag_r[5]) else $error("falling edge did not set flag");

  // A falling edge is ignored while rising polarity is chosen.
  fall_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
    s_armed(6) ##0 s_single_edge(6) ##0 (pol_r[6] && !pin_in[6] && !flag_r[6])
    |=> !flag_r[6]) else $error("wrong edge set flag");

  // A rising edge is ignored while falling polarity is chosen.
  rise_ignored_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
    s_armed(10) ##0 s_single_edge(10) ##0
    (!pol_r[10] && pin_in[10] && !pin_prev_r[10] && !flag_r[10])
    |=> !flag_r[10]) else $error("wrong edge set flag");

  // A low level with low polarity sets the flag.
  level_low_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    s_armed(1) ##0 s_level(1) ##0 (!pol_r[1] && !pin_in[1])
    |=> flag_r[1]) else $error("low level did not set flag");

  // A high level with high polarity sets the flag.
  level_high_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    s_armed(7) ##0 s_level(7) ##0 (pol_r[7] && pin_in[7])
    |=> flag_r[7]) else $error("high level did not set flag");

  // A high level with low polarity leaves a clear flag alone.
  level_wrong_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    s_armed(9) ##0 s_level(9) ##0 (!pol_r[9] && pin_in[9] && !flag_r[9])
    |=> !flag_r[9]) else $error("wrong level set flag");

  // Dual edge catches a rise even with falling polarity.
  dual_rise_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R9]
    s_armed(10) ##0 s_both_edges(10) ##0 (!pol_r[10] && pin_in[10] && !pin_prev_r[10])
    |=> flag_r[10]) else $error("dual edge missed rise");

  // Dual edge catches a fall even with rising polarity.
  dual_fall_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R9]
    s_armed(11) ##0 s_both_edges(11) ##0 (pol_r[11] && !pin_in[11] && pin_prev_r[11])
    |=> flag_r[11]) else $error("dual edge missed fall");

  // In edge mode a steady pin never sets the flag, whatever its level.
  edge_steady_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R19]
    s_armed(8) ##0 (trig_kind_r[8] && pin_in[8] == pin_prev_r[8] && !flag_r[8])
    |=> !flag_r[8]) else $error("steady pin set flag in edge mode");

  // The mode register takes the written bits.
  mode_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R19]
    (reg_wr && reg_addr == OFF_MODE) |=> trig_kind_r == $past(reg_wdata[NPIN-1:0]))
    else $error("mode write lost");

  // A disabled pin never raises its flag.
  disabled_no_set_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R3]
    (!en_r[0] && !flag_r[0]) |=> !flag_r[0]) else $error("flag set while disabled");

  // The polarity register takes the written bits.
  pol_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    (reg_wr && reg_addr == OFF_POL) |=> pol_r == $past(reg_wdata[NPIN-1:0]))
    else $error("polarity write lost");

  // Each pin's enable is its own bit.
  enable_gates_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
    (!en_r[12] && !flag_r[12]) |=> !flag_r[12]) else $error("flag set while disabled");

  // The enable register takes the written bits.
  en_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
    (reg_wr && reg_addr == OFF_EN) |=> en_r == $past(reg_wdata[NPIN-1:0]))
    else $error("enable write lost");

  // A pending flag survives anything but a clear, the enable included.
  flag_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
    (flag_r[2] && !clr_w[2]) |=> flag_r[2]) else $error("flag lost without clear");

  // A clear with no new hit drops the flag.
  clear_works_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
    (clr_w[3] && !hit[3]) |=> !flag_r[3]) else $error("clear ignored");

  // A zero in the clear word leaves that flag alone.
  clear_others_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
    (reg_wr && reg_addr == OFF_CLR && flag_r[3] && !reg_wdata[3])
    |=> flag_r[3]) else $error("zero bit cleared flag");

  // The clear register reads back as zero.
  read_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R7]
    (reg_rd && reg_addr == OFF_CLR) |=> reg_rdata == 32'h00000000)
    else $error("clear register read not zero");

  // After a clear the detector is armed again for the next edge.
  edge_rearm_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R20]
    (clr_w[13] && !hit[13]) ##1 hit[13] |=> flag_r[13])
    else $error("edge after clear lost");

  // A pin in an alternate function never raises its flag.
  altfunc_block_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R21]
    (af0_r[4] && !flag_r[4]) |=> !flag_r[4]) else $error("flag in alt function");

  // Same for the second select bit.
  altfunc_hi_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R21]
    (af1_r[12] && !flag_r[12]) |=> !flag_r[12]) else $error("flag in alt function");

  // The request follows any enabled pending flag.
  irq_out_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R22]
    (flag_r[0] && en_r[0]) |-> irq_out) else $error("irq output missing");

  // No request without an enabled pending flag.
  irq_low_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R22]
    (flag_r & en_r) == RST_ZERO |-> !irq_out) else $error("irq output spurious");

  // Flags come out of reset clear.
  flags_zero_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
    !$past(resetn) |-> flag_r == RST_ZERO) else $error("flags not zero after reset");

  // A read of the flag register returns the flags of the strobe cycle.
  read_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
    (reg_rd && reg_addr == OFF_FL) |=> reg_rdata[NPIN-1:0] == $past(flag_r))
    else $error("flag readback wrong");

  // Writing the flag register itself changes nothing.
  flag_ro_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
    (reg_wr && reg_addr == OFF_FL && hit == RST_ZERO) |=> flag_r == $past(flag_r))
    else $error("flag register written");

  // Read data are zero outside the cycle after a read strobe.
  read_idle_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
    !reg_rd |=> reg_rdata == 32'h00000000) else $error("read data outside slot");

  // An edge event on a wake-enabled pin asks for wakeup.
  wake_on_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
    (flag_r[4] && wake_r[4] && trig_kind_r[4]) |-> wakeup_req[4])
    else $error("wakeup missing");

  // A pin without wake enable never asks for wakeup.
  wake_off_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
    !wake_r[5] |-> !wakeup_req[5]) else $error("wakeup while disabled");

  // Level events cannot wake, as levels need a running clock.
  wake_level_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
    !trig_kind_r[6] |-> !wakeup_req[6]) else $error("wakeup from level");

  // General pins pull up when enabled and pull-up is selected.
  pullup_general_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
    (pull_r[12] && psel_r[12]) |-> pad_pull_up_en[12] && !pad_pull_down_en[12])
    else $error("general pin pull-up wrong");

  // General pins pull down when enabled and pull-down is selected.
  pulldown_general_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
    (pull_r[13] && !psel_r[13]) |-> pad_pull_down_en[13] && !pad_pull_up_en[13])
    else $error("general pin pull-down wrong");

  // No resistor at all without the enable.
  pull_off_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
    !pull_r[0] |-> !pad_pull_up_en[0] && !pad_pull_down_en[0])
    else $error("resistor on while disabled");

  // Serial pins never pull up, and drop the pull-down if pull-up is asked.
  pullup_serial_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R11]
    !pad_pull_up_en[8] && !(pad_pull_down_en[9] && psel_r[9]))
    else $error("serial pin pull wrong");

  // The two select bits reach the pad mux as one field.
  func_sel_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R12]
    pad_func_sel[9:8] == {af1_r[4], af0_r[4]}) else $error("function select wrong");

  // The hysteresis bit drives the input stage.
  schmitt_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R13]
    pad_schmitt_en[5] == hys_r[5]) else $error("schmitt control wrong");

  // General pins get the slew bit as written.
  slew_general_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R14]
    pad_slow_slew[1:0] == sr_r[1:0]) else $error("slew control wrong");

  // Serial pins have no slew control at all.
  slew_serial_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R15]
    pad_slow_slew[3:2] == 2'h0 && pad_slow_slew[9:8] == 2'h0)
    else $error("serial pin slew set");

  // General pins take both drive bits.
  drive_general_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R16]
    {pad_drive_hi[4], pad_drive_lo[4]} == {ds1_r[4], ds0_r[4]})
    else $error("drive mode wrong");

  // Serial pins use the first drive bit only.
  drive_serial_a: assert property (@(posedge core_clk) disable iff (!resetn) // [R17]
    !pad_drive_hi[8] && !pad_drive_hi[3] && pad_drive_lo[3] == ds0_r[3])
    else $error("serial pin drive wrong");
endmodule

// File: tb/gpipc_pad_model.sv
// Model of the external pads that feed the port's pin inputs.
// Assumes the bench chooses which pads are driven and to what level.
`timescale 1ns/100ps
module gpipc_pad_model (
  input wire logic core_clk,
  input wire logic [13:0] drv_en,
  input wire logic [13:0] drv_val,
  input wire logic [13:0] pull_up,
  input wire logic [13:0] pull_down,
  output logic [13:0] pin_in
);
  logic [13:0] last_r = 14'h0000;
  // A floating pad has no stable level, so it flips every cycle.
  // This exposes logic that wrongly treats it as holding its last value.
  always_ff @(posedge core_clk) begin
    last_r <= pin_in;
  end
  // A driven pad wins; otherwise an enabled resistor sets the level.
  always_comb begin
    pin_in = (drv_en & drv_val) | (~drv_en & pull_up)
      | (~drv_en & ~pull_up & ~pull_down & ~last_r);
  end
endmodule

// File: tb/gpio_pin_irq_and_pad_config_tb.sv
// Self-checking bench for the pin interrupt and pad configuration block.
// Assumes the pad model beside it and the design's one-cycle register port.
`timescale 1ns/100ps
module gpio_pin_irq_and_pad_config_tb;
  import gpipc_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq_out;
  logic [AW-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [NPIN-1:0] pin_in, wakeup_req, pu, pd, schm, slow, dlo, dhi;
  logic [NPIN-1:0] drv_en = 14'h0000, drv_val = 14'h0000;
  logic [2*NPIN-1:0] fsel;
  int num_errors = 0, tests_run = 0, cycles = 0;
  localparam logic [AW-1:0] OFFS [11] = '{OFF_POL, OFF_EN, OFF_FL, OFF_WAKE, OFF_DUAL,
    OFF_PULL, OFF_AF1, OFF_HYS, OFF_SR, OFF_DS0, OFF_DS1};
  localparam logic [31:0] GEN = {18'h0, GENERAL_PINS};
  gpipc_top DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .irq_out(irq_out), .wakeup_req(wakeup_req), .pad_pull_up_en(pu),
    .pad_pull_down_en(pd), .pad_schmitt_en(schm), .pad_slow_slew(slow),
    .pad_drive_lo(dlo), .pad_drive_hi(dhi), .pad_func_sel(fsel));
  gpipc_pad_model pads (.core_clk(core_clk), .drv_en(drv_en), .drv_val(drv_val),
    .pull_up(pu), .pull_down(pd), .pin_in(pin_in));
  // Clock at 10 MHz.
  always #50 core_clk = ~core_clk;
  // Cuts a hang short; the whole run needs under two hundred cycles.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write; upper bits always go out as zero.
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= {18'h0, d[13:0]};
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Outputs launched by the write settle before any check that follows.
    @(negedge core_clk);
  endtask
  // One-cycle read; the data stand only in the following cycle.
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp, what);
  endtask
  // Moves the driven pad levels and lets the detector settle.
  task automatic pins(input logic [NPIN-1:0] v);
    @(posedge core_clk);
    drv_val <= v;
    repeat (4) @(posedge core_clk);
  endtask
  // Main sequence: reset, register map, pad controls, interrupt paths, then pull-up and function select.
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    drv_en <= 14'h3fff;
    foreach (OFFS[i]) rd(OFFS[i], 32'h0, "reset value");
    rd(8'hf0, 32'h0, "unmapped");
    foreach (OFFS[i]) wr(OFFS[i], 32'h3fff);
    wr(OFF_MODE, 32'h3fff);
    foreach (OFFS[i]) rd(OFFS[i], (OFFS[i] == OFF_SR || OFFS[i] == OFF_DS1) ? GEN :
      (OFFS[i] == OFF_FL) ? 32'h0 : 32'h3fff, "readback");
    chk({18'h0, schm}, 32'h3fff, "schmitt");
    chk({18'h0, slow}, GEN, "slew");
    chk({4'h0, dhi, dlo}, {4'h0, GENERAL_PINS, 14'h3fff}, "drive");
    chk({4'h0, pu, pd}, {18'h0, 14'h3fff}, "pull down");
    pins(14'h3fff);
    rd(OFF_FL, 32'h0, "flags in alt function");
    wr(OFF_AF1, 32'h0);
    wr(OFF_DUAL, 32'h0);
    pins(14'h0000);
    rd(OFF_FL, 32'h0, "falling ignored");
    pins(14'h3fff);
    rd(OFF_FL, 32'h3fff, "rising");
    chk({31'h0, irq_out}, 32'h1, "irq");
    chk({18'h0, wakeup_req}, 32'h3fff, "wake");
    wr(OFF_WAKE, 32'h0);
    chk({18'h0, wakeup_req}, 32'h0, "wake off");
    wr(OFF_CLR, 32'h00ff);
    rd(OFF_FL, 32'h3f00, "partial clear");
    wr(OFF_EN, 32'h0);
    rd(OFF_FL, 32'h3f00, "flags kept");
    chk({31'h0, irq_out}, 32'h0, "irq masked");
    wr(OFF_CLR, 32'h3fff);
    wr(OFF_EN, 32'h3fff);
    wr(OFF_DUAL, 32'h3fff);
    pins(14'h0000);
    rd(OFF_FL, 32'h3fff, "dual edge");
    wr(OFF_CLR, 32'h3fff);
    wr(OFF_MODE, 32'h0);
    wr(OFF_POL, 32'h0);
    rd(OFF_FL, 32'h3fff, "level low");
    wr(OFF_EN, 32'h0);
    wr(OFF_CLR, 32'h3fff);
    rd(OFF_FL, 32'h0, "disabled level");
    wr(OFF_POL, 32'h3fff);
    wr(OFF_EN, 32'h0001);
    rd(OFF_FL, 32'h0, "level high idle");
    pins(14'h3fff);
    rd(OFF_FL, 32'h0001, "level high");
    wr(OFF_PSEL, 32'h3fff);
    chk({4'h0, pu, pd}, {4'h0, GENERAL_PINS, 14'h0}, "pull up");
    wr(OFF_AF0, 32'h3fff);
    chk({4'h0, fsel}, 32'h05555555, "function one");
    wr(OFF_AF1, 32'h3fff);
    chk({4'h0, fsel}, 32'h0fffffff, "function three");
    tally_and_finish();
  end
endmodule
